//--- pkg/osc_monitor_pkg.sv
package osc_monitor_pkg;
  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int CMP_W = 12;
  localparam logic [7:0] MODE_KEY = 8'h3C;
  localparam logic [CMP_W-1:0] CMP_RESET = 12'h0FFF;
  localparam logic [CMP_W-1:0] CMP_MIN = 12'h0003;
  localparam int MODE_KEY_LSB = 8;
  localparam int MODE_TARGET_BIT = 0;
  localparam int MODE_ACTION_BIT = 1;
  localparam logic TARGET_MAIN = 1'b0;
  localparam logic TARGET_SUB = 1'b1;
  localparam logic ACTION_IRQ = 1'b0;
  localparam logic ACTION_RESET = 1'b1;
  localparam int HOCO_DIV = 8;
  typedef enum logic [1:0] {
    CPU_SRC_MAIN,
    CPU_SRC_PLL_MAIN,
    CPU_SRC_SUB,
    CPU_SRC_OTHER
  } cpu_src_t;
  typedef enum logic [1:0] {
    CPU_CLK_NORMAL,
    CPU_CLK_HOCO_DIV8,
    CPU_CLK_LOW_SPEED
  } cpu_clk_sel_t;
endpackage

//--- pkg/osc_watch_if.sv
`timescale 1ns/1ps
interface osc_watch_if;
  logic enable;
  logic restart;
  logic [osc_monitor_pkg::CMP_W-1:0] compare;
  logic low_speed_tick;
  logic expired;
  modport ctrl (output enable, output restart, output compare,
    output low_speed_tick, input expired);
  modport counter (input enable, input restart, input compare,
    input low_speed_tick, output expired);
endinterface

//--- logic/stop_time_counter.sv
`timescale 1ns/1ps
module stop_time_counter (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  osc_watch_if.counter watch
);
  import osc_monitor_pkg::*;

  logic [CMP_W:0] count;

  // ----------------------------------------
  // low-speed cycle count
  // ----------------------------------------
  // extra bit so compare 0xFFF + 1 does not wrap
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !watch.enable || watch.restart) begin
      count <= '0;
    end else if (watch.low_speed_tick && !watch.expired) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !watch.enable || watch.restart) begin
      watch.expired <= 1'b0;
    end else if (watch.low_speed_tick &&
                 (count + 1'b1) >= ({1'b0, watch.compare} + 1'b1)) begin
      watch.expired <= 1'b1;
    end
  end
endmodule

//--- logic/oscillation_stop_monitor.sv
`timescale 1ns/1ps
module oscillation_stop_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic internal_reset_i,
  input wire logic main_system_clock_i,
  input wire logic sub_system_clock_i,
  input wire logic low_speed_internal_osc_i,
  input wire logic monitor_clock_gate_enable_i,
  input wire logic mode_wr_i,
  input wire logic [15:0] mode_wdata_i,
  input wire logic ctrl_wr_i,
  input wire logic [15:0] ctrl_wdata_i,
  input wire logic status_wr_i,
  input wire logic [7:0] status_wdata_i,
  input wire logic deep_sleep_i,
  input wire logic standby_release_i,
  input wire logic low_speed_clock_source_select_i,
  input wire logic wdog_standby_run_i,
  input wire logic wdog_enable_option_i,
  input wire osc_monitor_pkg::cpu_src_t cpu_src_i,
  output logic [15:0] clock_monitor_mode_reg_o,
  output logic [15:0] clock_monitor_control_reg_o,
  output logic [7:0] clock_monitor_status_reg_o,
  output logic stop_irq_o,
  output logic stop_reset_o,
  output osc_monitor_pkg::cpu_clk_sel_t cpu_clk_sel_o
);
  import osc_monitor_pkg::*;

  logic target_sel;
  logic action_sel;
  logic run_enable;
  logic [CMP_W-1:0] compare;
  logic stop_flag;
  logic sleeping;
  logic [1:0] main_sync;
  logic [1:0] sub_sync;
  logic [1:0] lso_sync;
  logic watched_prev;
  logic lso_prev;
  logic expired_prev;
  logic expired_rise;
  cpu_clk_sel_t next_cpu_sel;
  osc_watch_if watch ();

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      main_sync <= 2'h0;
      sub_sync <= 2'h0;
      lso_sync <= 2'h0;
    end else begin
      main_sync <= {main_sync[0], main_system_clock_i};
      sub_sync <= {sub_sync[0], sub_system_clock_i};
      lso_sync <= {lso_sync[0], low_speed_internal_osc_i};
    end
  end

  function automatic logic watched_level(input logic sel,
                                         input logic [1:0] m,
                                         input logic [1:0] s);
    watched_level = (sel == TARGET_SUB) ? s[1] : m[1];
  endfunction

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      watched_prev <= 1'b0;
      lso_prev <= 1'b0;
    end else begin
      watched_prev <= watched_level(target_sel, main_sync, sub_sync);
      lso_prev <= lso_sync[1];
    end
  end

  // ----------------------------------------
  // mode register
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      target_sel <= TARGET_MAIN;
      action_sel <= ACTION_IRQ;
    end else if (mode_wr_i &&
                 mode_wdata_i[15:MODE_KEY_LSB] == MODE_KEY) begin
      target_sel <= mode_wdata_i[MODE_TARGET_BIT];
      action_sel <= mode_wdata_i[MODE_ACTION_BIT];
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // compare accepted only while stopped; values below 3 are software's fault
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || internal_reset_i) begin
      run_enable <= 1'b0;
      compare <= CMP_RESET;
    end else if (ctrl_wr_i) begin
      run_enable <= ctrl_wdata_i[15] && monitor_clock_gate_enable_i;
      if (!run_enable) begin
        compare <= ctrl_wdata_i[CMP_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // deep sleep suspend
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || internal_reset_i) begin
      sleeping <= 1'b0;
    end else if (standby_release_i) begin
      sleeping <= 1'b0;
    end else if (deep_sleep_i) begin
      sleeping <= 1'b1;
    end
  end

  // ----------------------------------------
  // counter hookup
  // ----------------------------------------
  assign watch.enable = run_enable && !sleeping && monitor_clock_gate_enable_i
    && (low_speed_clock_source_select_i
        || (wdog_standby_run_i && wdog_enable_option_i));
  assign watch.restart =
    watched_level(target_sel, main_sync, sub_sync) != watched_prev;
  assign watch.compare = compare;
  assign watch.low_speed_tick = lso_sync[1] && !lso_prev;

  stop_time_counter u_counter (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .watch(watch)
  );

  // ----------------------------------------
  // detection edge
  // ----------------------------------------
  // expired stays up until the watched clock moves; act once per stop.
  // not cleared by internal reset, else a still-high expired looks new
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      expired_prev <= 1'b0;
    end else begin
      expired_prev <= watch.expired;
    end
  end

  assign expired_rise = watch.expired && !expired_prev;

  // ----------------------------------------
  // stop flag and outputs
  // ----------------------------------------
  // set wins over a same-cycle software clear
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || internal_reset_i) begin
      stop_flag <= 1'b0;
    end else if (expired_rise) begin
      stop_flag <= 1'b1;
    end else if (status_wr_i && !status_wdata_i[0]) begin
      stop_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || internal_reset_i) begin
      stop_irq_o <= 1'b0;
      stop_reset_o <= 1'b0;
    end else begin
      stop_irq_o <= expired_rise && action_sel == ACTION_IRQ;
      stop_reset_o <= expired_rise && action_sel == ACTION_RESET;
    end
  end

  always_comb begin
    next_cpu_sel = cpu_clk_sel_o;
    if (expired_rise && target_sel == TARGET_MAIN &&
        (cpu_src_i == CPU_SRC_MAIN || cpu_src_i == CPU_SRC_PLL_MAIN)) begin
      next_cpu_sel = CPU_CLK_HOCO_DIV8;
    end else if (expired_rise && target_sel == TARGET_SUB &&
                 cpu_src_i == CPU_SRC_SUB) begin
      next_cpu_sel = CPU_CLK_LOW_SPEED;
    end else if (status_wr_i && !status_wdata_i[0]) begin
      next_cpu_sel = CPU_CLK_NORMAL;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cpu_clk_sel_o <= CPU_CLK_NORMAL;
    end else begin
      cpu_clk_sel_o <= next_cpu_sel;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      clock_monitor_mode_reg_o <= 16'h0000;
      clock_monitor_control_reg_o <= {4'h0, CMP_RESET};
      clock_monitor_status_reg_o <= 8'h00;
    end else begin
      clock_monitor_mode_reg_o <= {14'h0000, action_sel, target_sel};
      clock_monitor_control_reg_o <= {run_enable, 3'h0, compare};
      clock_monitor_status_reg_o <= {7'h00, stop_flag};
    end
  end
endmodule

//--- tb/osc_source_model.sv
`timescale 1ns/1ps
module osc_source_model (
  input wire logic main_run_i,
  input wire logic sub_run_i,
  output logic main_clk_o,
  output logic sub_clk_o,
  output logic low_clk_o
);
  // a stopped crystal freezes at its last level
  initial {main_clk_o, sub_clk_o, low_clk_o} = 3'b000;
  always #20 low_clk_o = ~low_clk_o;
  always #10 if (main_run_i) main_clk_o = ~main_clk_o;
  always #10 if (sub_run_i) sub_clk_o = ~sub_clk_o;
endmodule

//--- tb/oscillation_stop_monitor_monitor.sv
`timescale 1ns/1ps
module oscillation_stop_monitor_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic internal_reset_i,
  input wire logic mode_wr_i,
  input wire logic [15:0] mode_wdata_i,
  input wire logic status_wr_i,
  input wire osc_monitor_pkg::cpu_src_t cpu_src_i,
  input wire logic [15:0] clock_monitor_mode_reg_o,
  input wire logic [7:0] clock_monitor_status_reg_o,
  input wire logic stop_irq_o,
  input wire logic stop_reset_o,
  input wire osc_monitor_pkg::cpu_clk_sel_t cpu_clk_sel_o
);
  import osc_monitor_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire hit = stop_irq_o | stop_reset_o;
  wire [1:0] md = clock_monitor_mode_reg_o[1:0];
  wire fl = clock_monitor_status_reg_o[0];
  a_irq_action: assert property (stop_irq_o |-> !md[1])
    else $error("irq under reset action");
  a_reset_action: assert property (stop_reset_o |-> md[1])
    else $error("reset under irq action");
  a_pulse_single: assert property (hit |=> !hit)
    else $error("pulse too long");
  a_flag_set: assert property (hit |=> fl)
    else $error("flag not set");
  a_flag_sticky: assert property (
    fl && !status_wr_i && !$past(status_wr_i) && !internal_reset_i
    && !$past(internal_reset_i) |=> fl)
    else $error("flag dropped");
  a_main_fallback: assert property (
    hit && !md[0] && cpu_src_i inside {CPU_SRC_MAIN, CPU_SRC_PLL_MAIN}
    |-> cpu_clk_sel_o == CPU_CLK_HOCO_DIV8) else $error("no hoco");
  a_sub_fallback: assert property (
    hit && md[0] && cpu_src_i == CPU_SRC_SUB
    |-> cpu_clk_sel_o == CPU_CLK_LOW_SPEED) else $error("no low");
  a_key_guard: assert property (
    mode_wr_i && mode_wdata_i[15:8] != MODE_KEY
    |=> ##1 $stable(clock_monitor_mode_reg_o)) else $error("keyless");
endmodule
bind oscillation_stop_monitor oscillation_stop_monitor_monitor u_mon (
  .clk_sys_i, .rst_i, .internal_reset_i, .mode_wr_i, .mode_wdata_i,
  .status_wr_i, .cpu_src_i, .clock_monitor_mode_reg_o,
  .clock_monitor_status_reg_o, .stop_irq_o, .stop_reset_o, .cpu_clk_sel_o);

//--- tb/oscillation_stop_monitor_tb.sv
`timescale 1ns/1ps
module oscillation_stop_monitor_tb;
  import osc_monitor_pkg::*;
  logic clk_sys_i = 0, rst_i = 1, gate = 0, sleep = 0, wake = 0;
  logic lsel = 1, wsb = 1, wen = 1, ires = 0;
  logic m_run = 1, s_run = 1, mclk, sclk, lclk, irq, rout;
  logic [2:0] ws = 0;
  logic [15:0] wd = 0, mode, ctrl;
  logic [7:0] stat;
  cpu_src_t src = CPU_SRC_MAIN;
  cpu_clk_sel_t sel;
  int failures = 0, compares = 0, hits = 0, n;
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) hits <= hits + int'(irq | rout);
  osc_source_model u_src (.main_run_i(m_run), .sub_run_i(s_run),
    .main_clk_o(mclk), .sub_clk_o(sclk), .low_clk_o(lclk));
  oscillation_stop_monitor u_dut (.clk_sys_i, .rst_i,
    .internal_reset_i(ires), .main_system_clock_i(mclk),
    .sub_system_clock_i(sclk), .low_speed_internal_osc_i(lclk),
    .monitor_clock_gate_enable_i(gate), .mode_wr_i(ws[2]),
    .mode_wdata_i(wd), .ctrl_wr_i(ws[1]), .ctrl_wdata_i(wd),
    .status_wr_i(ws[0]), .status_wdata_i(wd[7:0]),
    .deep_sleep_i(sleep), .standby_release_i(wake),
    .low_speed_clock_source_select_i(lsel), .wdog_standby_run_i(wsb),
    .wdog_enable_option_i(wen), .cpu_src_i(src),
    .clock_monitor_mode_reg_o(mode), .clock_monitor_control_reg_o(ctrl),
    .clock_monitor_status_reg_o(stat), .stop_irq_o(irq),
    .stop_reset_o(rout), .cpu_clk_sel_o(sel));
  task automatic cmp(input logic [15:0] g, e);
    compares++;
    failures += int'(g !== e);
    if (g !== e) $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task automatic summarize;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    wd <= d;
    ws <= s;
    tick(1);
    ws <= 3'b000;
    tick(1);
  endtask
  task automatic wt;
    for (n = 0; (irq | rout) !== 1'b1 && n < 1000; n++) tick(1);
    failures += int'(n == 1000);
    if (n == 1000) summarize();
  endtask
  task automatic t_quiet;
    wr(3'b100, 16'h3d03);
    cmp(mode, 16'h0000);
    m_run <= 0;
    n = hits;
    tick(100);
    cmp(16'(hits - n), 16'h0000);
    wr(3'b010, 16'h8003);
    sleep <= 1;
    n = hits;
    tick(100);
    cmp(16'(hits - n), 16'h0000);
    {sleep, wake} <= 2'b01;
    tick(1);
    wake <= 0;
    wt();
    m_run <= 1;
    wr(3'b001, 16'h0000);
    $display("quiet done");
  endtask
  task automatic t_detect(input logic t, a, input cpu_src_t s,
      input cpu_clk_sel_t e, input logic [11:0] c);
    src <= s;
    wr(3'b100, {8'h3c, 6'h00, a, t});
    wr(3'b010, {4'h0, c});
    wr(3'b010, {4'h0, c});
    wr(3'b010, {4'h8, c});
    cmp(mode, {14'h0000, a, t});
    cmp(ctrl, {4'h8, c});
    {m_run, s_run} <= {t, !t};
    wt();
    // slack covers sync delay and the stop landing mid-period
    cmp({15'h0000, n + 4 >= c * 8 && n <= c * 8 + 16}, 16'h0001);
    cmp({14'h0000, rout, irq}, {14'h0000, a, !a});
    cmp({14'h0000, sel}, {14'h0000, e});
    tick(1);
    cmp({8'h00, stat}, 16'h0001);
    {m_run, s_run} <= 2'b11;
    wr(3'b001, 16'h0000);
    cmp({14'h0000, sel}, 16'h0000);
    cmp({8'h00, stat}, 16'h0000);
    $display("detect %0d %0d done", t, a);
  endtask
  task automatic t_gate;
    wr(3'b010, 16'h8007);
    cmp(ctrl, 16'h8005);
    {lsel, wsb, wen} <= 3'b010;
    s_run <= 0;
    n = hits;
    tick(100);
    {wsb, wen} <= 2'b01;
    tick(100);
    cmp(16'(hits - n), 16'h0000);
    wsb <= 1;
    wt();
    cmp({14'h0000, rout, irq}, 16'h0002);
    ires <= 1;
    tick(1);
    ires <= 0;
    tick(1);
    cmp(ctrl, 16'h0fff);
    cmp({8'h00, stat}, 16'h0000);
    n = hits;
    tick(100);
    cmp(16'(hits - n), 16'h0000);
    {s_run, lsel} <= 2'b11;
    $display("gate done");
  endtask
  initial begin
    tick(2);
    rst_i <= 0;
    gate <= 1;
    tick(1);
    wr(3'b001, 16'h0000);
    cmp({8'h00, stat}, 16'h0000);
    t_quiet();
    t_detect(0, 0, CPU_SRC_MAIN, CPU_CLK_HOCO_DIV8, 12'h003);
    t_detect(0, 1, CPU_SRC_PLL_MAIN, CPU_CLK_HOCO_DIV8, 12'h00a);
    t_detect(1, 0, CPU_SRC_SUB, CPU_CLK_LOW_SPEED, 12'h003);
    t_detect(1, 1, CPU_SRC_OTHER, CPU_CLK_NORMAL, 12'h005);
    t_gate();
    summarize();
  end
endmodule
